/* File: design/crsf_core.sv */
// Execution unit for user-stack push, carry clear, return, rotates and bank-0 select.
`timescale 1ns/10ps
module crsf_core
    import crsf_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Instruction from fetch/decode
    input wire logic INSTR_VALID,
    input wire crsf_instr_type INSTR,
    output logic INSTR_READY,
    output logic INSTR_DONE,
    // Register file read ports (combinational answer)
    output logic [7:0] RF_RADDR_A,
    input wire logic [7:0] RF_RDATA_A,
    output logic [7:0] RF_RADDR_B,
    input wire logic [7:0] RF_RDATA_B,
    // Register file write port
    output crsf_regwr_type RF_WRITE,
    // Stack memory read port (combinational answer)
    output logic [15:0] STACK_ADDR,
    input wire logic [7:0] STACK_RDATA,
    // Architectural state
    output logic [7:0] FLAGS,
    output logic [15:0] STACK_POINTER,
    output logic [15:0] PROGRAM_COUNTER,
    output logic PC_LOAD
);

    // ************************************************************
    // State machine and registers
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_SECOND = 3'b010,
        ST_WAIT = 3'b011
    } crsf_state_type;

    crsf_state_type state_q, state_d;
    crsf_instr_type instr_q;
    logic [3:0] cnt_q;
    logic [7:0] flags_q;
    logic [15:0] sp_q;
    logic [15:0] pc_q;
    logic [7:0] pc_hi_q;
    logic pc_load_q;
    logic done_q;
    logic ready_q;
    crsf_regwr_type wr_q;
    logic [7:0] raddr_a_q, raddr_b_q;
    logic [15:0] stack_addr_q;

    // Cycle count for an instruction; a function keeps decode in one place.
    function automatic logic [3:0] cycles_of(input logic [7:0] opc);
        case (opc)
            OPC_USER_PUSH_UP: cycles_of = CYC_PUSH_UP;
            OPC_SUB_EXIT: cycles_of = CYC_SUB_EXIT;
            default: cycles_of = CYC_SHORT;
        endcase
    endfunction : cycles_of

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic [7:0] opc_w = instr_q.opcode;
    wire logic is_push_w = (opc_w == OPC_USER_PUSH_UP);
    wire logic is_clrc_w = (opc_w == OPC_CLEAR_CARRY);
    wire logic is_ret_w = (opc_w == OPC_SUB_EXIT);
    wire logic is_sb0_w = (opc_w == OPC_SEL_BANK_ZERO);
    wire logic is_rot_w = (opc_w[7:1] == OPC_ROT_LEFT[7:1]) ||
                          (opc_w[7:1] == OPC_ROT_LEFT_C[7:1]) ||
                          (opc_w[7:1] == OPC_ROT_RIGHT[7:1]) ||
                          (opc_w[7:1] == OPC_ROT_RIGHT_C[7:1]);
    wire logic pointer_operand_mode = opc_w[0];
    wire crsf_rot_type rot_kind_w =
        (opc_w[7:1] == OPC_ROT_LEFT[7:1]) ? ROT_L :
        (opc_w[7:1] == OPC_ROT_LEFT_C[7:1]) ? ROT_LC :
        (opc_w[7:1] == OPC_ROT_RIGHT[7:1]) ? ROT_R : ROT_RC;
    // Ready stays low for one cycle after reset, so an offer held across the release
    // waits for it; taking on the idle state alone would accept a refused request.
    wire logic take_w = (state_q == ST_IDLE) && INSTR_VALID && ready_q;
    wire logic last_w = (state_q == ST_WAIT) && (cnt_q == 4'h1);

    // Rotate operand address: the register itself, or the register it points at.
    wire logic [7:0] rot_addr_w = pointer_operand_mode ? RF_RDATA_A : instr_q.arg1;

    // ************************************************************
    // Rotate datapath
    // ************************************************************
    logic [7:0] rot_res_w;
    logic rot_c_w, rot_z_w, rot_s_w, rot_v_w;

    crsf_rotator u_rot (
        .kind(rot_kind_w),
        .operand(RF_RDATA_B),
        .carry_in(flags_q[FLAG_C]),
        .result(rot_res_w),
        .carry_out(rot_c_w),
        .zero_out(rot_z_w),
        .sign_out(rot_s_w),
        .ovf_out(rot_v_w)
    );

    // Push destination: pointer incremented before the write.
    wire logic [7:0] push_ptr_w = RF_RDATA_A + 8'h01;

    // Flags after a rotate; D, H and bank keep their values.
    wire logic [7:0] rot_flags_w = {rot_c_w, rot_z_w, rot_s_w, rot_v_w, flags_q[3:0]};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take_w) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d = (is_ret_w || is_push_w) ? ST_SECOND : ST_WAIT;
            end
            ST_SECOND: begin
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (cnt_q == 4'h1) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Sequencing
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            instr_q <= '0;
            cnt_q <= 4'h0;
            ready_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == ST_IDLE);
            done_q <= last_w;
            if (take_w) begin
                instr_q <= INSTR;
                cnt_q <= cycles_of(INSTR.opcode) - 4'h1;
            end else if (state_q != ST_IDLE && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    // ************************************************************
    // Register file and stack access
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            raddr_a_q <= 8'h00;
            raddr_b_q <= 8'h00;
            stack_addr_q <= STACK_RESET;
            wr_q <= '0;
        end else begin
            wr_q.we <= 1'b0;
            if (take_w) begin
                // Port A reads the pointer register, port B the push source.
                raddr_a_q <= INSTR.arg1;
                raddr_b_q <= INSTR.arg2;
                stack_addr_q <= sp_q;
            end else if (state_q == ST_EXEC && is_push_w) begin
                wr_q <= '{we: 1'b1, addr: raddr_a_q, data: push_ptr_w};
            end else if (state_q == ST_EXEC && is_rot_w) begin
                raddr_b_q <= rot_addr_w;
            end else if (state_q == ST_SECOND && is_push_w) begin
                wr_q <= '{we: 1'b1, addr: push_ptr_w, data: RF_RDATA_B};
            end else if (state_q == ST_EXEC && is_ret_w) begin
                stack_addr_q <= stack_addr_q + 16'h0001;
            end else if (state_q == ST_WAIT && cnt_q == CYC_SHORT - 4'h2 && is_rot_w) begin
                wr_q <= '{we: 1'b1, addr: raddr_b_q, data: rot_res_w};
            end
        end
    end

    // ************************************************************
    // Flags, stack pointer and program counter
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            flags_q <= FLAGS_RESET;
            sp_q <= STACK_RESET;
            pc_q <= PC_RESET;
            pc_hi_q <= 8'h00;
            pc_load_q <= 1'b0;
        end else begin
            pc_load_q <= 1'b0;
            if (state_q == ST_EXEC && is_clrc_w) begin
                flags_q[FLAG_C] <= 1'b0;
            end
            if (state_q == ST_EXEC && is_sb0_w) begin
                flags_q[FLAG_BANK] <= 1'b0;
            end
            if (state_q == ST_WAIT && cnt_q == CYC_SHORT - 4'h2 && is_rot_w) begin
                flags_q <= rot_flags_w;
            end
            if (state_q == ST_EXEC && is_ret_w) begin
                pc_hi_q <= STACK_RDATA;
            end
            if (state_q == ST_SECOND && is_ret_w) begin
                pc_q <= {pc_hi_q, STACK_RDATA};
                sp_q <= sp_q + STACK_STEP;
                pc_load_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign INSTR_READY = ready_q;
    assign INSTR_DONE = done_q;
    assign RF_RADDR_A = raddr_a_q;
    assign RF_RADDR_B = raddr_b_q;
    assign RF_WRITE = wr_q;
    assign STACK_ADDR = stack_addr_q;
    assign FLAGS = flags_q;
    assign STACK_POINTER = sp_q;
    assign PROGRAM_COUNTER = pc_q;
    assign PC_LOAD = pc_load_q;

endmodule : crsf_core

/* File: design/crsf_pkg.sv */
// Package of opcodes, flag positions, cycle counts and carrier types for the rotate/stack/flag unit.
package crsf_pkg;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OPC_USER_PUSH_UP = 8'h83;
    localparam logic [7:0] OPC_CLEAR_CARRY = 8'hcf;
    localparam logic [7:0] OPC_SUB_EXIT = 8'haf;
    localparam logic [7:0] OPC_ROT_LEFT = 8'h90;
    localparam logic [7:0] OPC_ROT_LEFT_IND = 8'h91;
    localparam logic [7:0] OPC_ROT_LEFT_C = 8'h10;
    localparam logic [7:0] OPC_ROT_LEFT_C_IND = 8'h11;
    localparam logic [7:0] OPC_ROT_RIGHT = 8'he0;
    localparam logic [7:0] OPC_ROT_RIGHT_IND = 8'he1;
    localparam logic [7:0] OPC_ROT_RIGHT_C = 8'hc0;
    localparam logic [7:0] OPC_ROT_RIGHT_C_IND = 8'hc1;
    localparam logic [7:0] OPC_SEL_BANK_ZERO = 8'h4f;

    // ************************************************************
    // Flag register bit positions, flag/stack/PC reset values and stack step
    // ************************************************************
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam int FLAG_BANK = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] STACK_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] STACK_STEP = 16'h0002;

    // ************************************************************
    // Cycle counts per instruction
    // ************************************************************
    localparam logic [3:0] CYC_PUSH_UP = 4'h8;
    localparam logic [3:0] CYC_SHORT = 4'h4;
    localparam logic [3:0] CYC_SUB_EXIT = 4'ha;

    // ************************************************************
    // Rotate kinds and carrier types
    // ************************************************************
    typedef enum logic [1:0] {
        ROT_L = 2'b00,
        ROT_LC = 2'b01,
        ROT_R = 2'b10,
        ROT_RC = 2'b11
    } crsf_rot_type;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] arg1;
        logic [7:0] arg2;
    } crsf_instr_type;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } crsf_regwr_type;

endpackage : crsf_pkg

/* File: design/crsf_rotator.sv */
// Combinational rotate unit producing the result byte and the new flag bits.
`timescale 1ns/10ps
module crsf_rotator
    import crsf_pkg::*;
(
    // Operand and mode
    input wire crsf_rot_type kind,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    // Result
    output logic [7:0] result,
    output logic carry_out,
    output logic zero_out,
    output logic sign_out,
    output logic ovf_out
);
    logic [7:0] res_w;

    assign res_w = (kind == ROT_L) ? {operand[6:0], operand[7]} :
                   (kind == ROT_LC) ? {operand[6:0], carry_in} :
                   (kind == ROT_R) ? {operand[0], operand[7:1]} :
                   {carry_in, operand[7:1]};
    assign result = res_w;
    assign carry_out = kind[1] ? operand[0] : operand[7];
    assign zero_out = (res_w == 8'h00);
    assign sign_out = res_w[7];
    // Overflow means the sign bit changed for every rotate kind.
    assign ovf_out = res_w[7] ^ operand[7];

endmodule : crsf_rotator

/* File: dv/crsf_core_assertions.sv */
// Concurrent checks on the ports of the rotate, stack and flag execution unit.
`timescale 1ns/10ps
module crsf_core_assertions
    import crsf_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Instruction handshake
    input wire logic INSTR_VALID,
    input wire crsf_instr_type INSTR,
    input wire logic INSTR_READY,
    input wire logic INSTR_DONE,
    // State and writes
    input wire crsf_regwr_type RF_WRITE,
    input wire logic [7:0] FLAGS,
    input wire logic [15:0] STACK_POINTER,
    input wire logic PC_LOAD
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence s_take(logic [7:0] op);
        INSTR_VALID && INSTR_READY && INSTR.opcode == op;
    endsequence

    chk_done_pulse: assert property (
        INSTR_DONE |=> !INSTR_DONE) else $error("done pulse longer than one cycle");
    chk_take_busy: assert property (
        INSTR_VALID && INSTR_READY |=> !INSTR_READY) else $error("ready stayed high after take");
    chk_clear_len: assert property (
        s_take(OPC_CLEAR_CARRY) |-> ##4 INSTR_DONE) else $error("clear carry length wrong");
    chk_carry_clear: assert property (
        s_take(OPC_CLEAR_CARRY) |-> ##2 (!FLAGS[FLAG_C] && FLAGS[6:0] == $past(FLAGS[6:0], 2)))
        else $error("carry clear touched wrong bits");
    chk_bank_zero: assert property (
        s_take(OPC_SEL_BANK_ZERO) |-> ##2 FLAGS == {$past(FLAGS[7:1], 2), 1'b0})
        else $error("bank select changed wrong bits");
    chk_push_flags: assert property (
        s_take(OPC_USER_PUSH_UP) |=> $stable(FLAGS) [*8]) else $error("push changed flags");
    chk_push_len: assert property (
        s_take(OPC_USER_PUSH_UP) |=> !INSTR_DONE [*7] ##1 INSTR_DONE)
        else $error("push length wrong");
    chk_exit_flags: assert property (
        s_take(OPC_SUB_EXIT) |=> $stable(FLAGS) [*8]) else $error("return changed flags");
    chk_exit_load: assert property (
        s_take(OPC_SUB_EXIT) |-> ##3 PC_LOAD) else $error("return never loaded counter");
    chk_exit_step: assert property (
        PC_LOAD |-> STACK_POINTER == $past(STACK_POINTER) + STACK_STEP)
        else $error("stack pointer not advanced by two");
    chk_rot_len: assert property (
        INSTR_VALID && INSTR_READY && (INSTR.opcode[7:1] == OPC_ROT_LEFT[7:1] ||
        INSTR.opcode[7:1] == OPC_ROT_LEFT_C[7:1] || INSTR.opcode[7:1] == OPC_ROT_RIGHT[7:1] ||
        INSTR.opcode[7:1] == OPC_ROT_RIGHT_C[7:1]) |-> ##4 INSTR_DONE)
        else $error("rotate length wrong");
    chk_write_busy: assert property (
        RF_WRITE.we |-> !INSTR_READY) else $error("register write while idle");
endmodule : crsf_core_assertions

/* File: dv/crsf_partner.sv */
// Register file and stack memory model facing the execution unit.
`timescale 1ns/10ps
module crsf_partner
    import crsf_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register file
    input wire logic [7:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [7:0] raddr_b,
    output logic [7:0] rdata_b,
    input wire crsf_regwr_type wr,
    // Stack memory
    input wire logic [15:0] stack_addr,
    output logic [7:0] stack_rdata
);
    logic [7:0] regs [256];
    logic [7:0] stk [256];
    // Only the low stack page exists; above it the data toggles so a stale byte never matches.
    assign rdata_a = regs[raddr_a];
    assign rdata_b = regs[raddr_b];
    assign stack_rdata = (stack_addr[15:8] == 8'h00) ? stk[stack_addr[7:0]] : {8{clk}};
    always @(posedge clk) begin
        if (wr.we) begin
            regs[wr.addr] <= wr.data;
        end
    end
endmodule : crsf_partner

/* File: dv/crsf_core_tb_top.sv */
// Self-checking bench for the rotate, stack and flag execution unit.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module crsf_core_tb_top
    import crsf_pkg::*;
;
    typedef struct packed {logic [7:0] op, val; logic cin; logic [7:0] res, fl;} crsf_row_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    crsf_instr_type instr = '0;
    logic instr_ready, instr_done, pc_load;
    logic [7:0] raddr_a, rdata_a, raddr_b, rdata_b, flags, f0, adr;
    logic [15:0] stack_addr, sp, pc;
    logic [7:0] stack_rdata;
    crsf_regwr_type rf_write;
    int errors = 0;
    int n_tests = 0;
    logic [7:0] pv [2] = '{8'h03, 8'hff};
    crsf_row_type rows [10] = '{
        '{OPC_ROT_LEFT, 8'haa, 1'b0, 8'h55, 8'h90}, '{OPC_ROT_LEFT_IND, 8'h17, 1'b1, 8'h2e, 8'h00},
        '{OPC_ROT_LEFT, 8'h00, 1'b1, 8'h00, 8'h40}, '{OPC_ROT_LEFT_C, 8'haa, 1'b0, 8'h54, 8'h90},
        '{OPC_ROT_LEFT_C_IND, 8'h17, 1'b1, 8'h2f, 8'h00},
        '{OPC_ROT_RIGHT, 8'h31, 1'b0, 8'h98, 8'hb0}, '{OPC_ROT_RIGHT_IND, 8'h17, 1'b0, 8'h8b, 8'hb0},
        '{OPC_ROT_RIGHT_C, 8'h55, 1'b0, 8'h2a, 8'h80},
        '{OPC_ROT_RIGHT_C_IND, 8'h17, 1'b1, 8'h8b, 8'hb0},
        '{OPC_ROT_RIGHT_C, 8'h01, 1'b0, 8'h00, 8'hc0}};

    always #20 clk = ~clk;

    crsf_core uut (.CLK(clk), .RST(rst), .INSTR_VALID(instr_valid), .INSTR(instr),
        .INSTR_READY(instr_ready), .INSTR_DONE(instr_done), .RF_RADDR_A(raddr_a),
        .RF_RDATA_A(rdata_a), .RF_RADDR_B(raddr_b), .RF_RDATA_B(rdata_b), .RF_WRITE(rf_write),
        .STACK_ADDR(stack_addr), .STACK_RDATA(stack_rdata), .FLAGS(flags),
        .STACK_POINTER(sp), .PROGRAM_COUNTER(pc), .PC_LOAD(pc_load));
    crsf_partner dut_mem (.clk(clk), .raddr_a(raddr_a), .rdata_a(rdata_a), .raddr_b(raddr_b),
        .rdata_b(rdata_b), .wr(rf_write), .stack_addr(stack_addr), .stack_rdata(stack_rdata));

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // The request is held until taken; completion is awaited under a bound.
    task automatic run(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2);
        int k;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= '{op, a1, a2};
        k = 0;
        do begin @(posedge clk); k++; end while (instr_ready !== 1'b1 && k < 20);
        instr_valid <= 1'b0;
        do begin @(posedge clk); k++; end while (instr_done !== 1'b1 && k < 60);
        if (instr_done !== 1'b1) begin
            errors++;
            wrap_up();
        end
    endtask : run

    task automatic set_carry(input logic c);
        if (c) begin
            dut_mem.regs[8'h40] = 8'h80;
            run(OPC_ROT_LEFT, 8'h40, 8'h00);
        end else begin
            f0 = flags;
            run(OPC_CLEAR_CARRY, 8'h00, 8'h00);
            `CHK(flags, f0 & 8'h7f)
        end
    endtask : set_carry

    initial begin
        for (int i = 0; i < 256; i++) begin
            dut_mem.regs[i] = 8'h00;
            dut_mem.stk[i] = 8'h00;
        end
        dut_mem.stk[0] = 8'h10;
        dut_mem.stk[1] = 8'h1a;
        dut_mem.stk[2] = 8'hab;
        dut_mem.stk[3] = 8'hcd;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK({flags, sp, pc, instr_ready}, {8'h00, 16'h0000, 16'h0000, 1'b1})
        for (int i = 0; i < 10; i++) begin
            set_carry(rows[i].cin);
            adr = rows[i].op[0] ? 8'h30 : 8'h10;
            dut_mem.regs[8'h20] = 8'h30;
            dut_mem.regs[adr] = rows[i].val;
            run(rows[i].op, rows[i].op[0] ? 8'h20 : 8'h10, 8'h00);
            `CHK(dut_mem.regs[adr], rows[i].res)
            `CHK(flags, rows[i].fl)
            `CHK(dut_mem.regs[8'h20], 8'h30)
        end
        // Pointer wrap from the top register back to zero is the awkward push case.
        for (int i = 0; i < 2; i++) begin
            set_carry(1'b1);
            dut_mem.regs[8'h05] = pv[i];
            dut_mem.regs[8'h06] = 8'h5a;
            f0 = flags;
            adr = pv[i] + 8'h01;
            run(OPC_USER_PUSH_UP, 8'h05, 8'h06);
            `CHK(dut_mem.regs[8'h05], adr)
            `CHK(dut_mem.regs[adr], 8'h5a)
            `CHK(flags, f0)
        end
        f0 = flags;
        run(OPC_SUB_EXIT, 8'h00, 8'h00);
        `CHK({pc, sp}, {16'h101a, 16'h0002})
        run(OPC_SUB_EXIT, 8'h00, 8'h00);
        `CHK({pc, sp, flags}, {16'habcd, 16'h0004, f0})
        run(OPC_SEL_BANK_ZERO, 8'h00, 8'h00);
        `CHK(flags, f0 & 8'hfe)
        // A second reset in mid-run must bring the non-zero state back to its reset values.
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK({flags, sp, pc, instr_ready}, {8'h00, 16'h0000, 16'h0000, 1'b1})
        wrap_up();
    end
endmodule : crsf_core_tb_top

bind crsf_core crsf_core_assertions u_chk (.CLK, .RST, .INSTR_VALID, .INSTR, .INSTR_READY,
    .INSTR_DONE, .RF_WRITE, .FLAGS, .STACK_POINTER, .PC_LOAD);
